// ### src/fsi_pkg.sv
package fsi_pkg;

  // Register indices; byte address is four times the index
  localparam logic [11:0] FSI_IDX_CONFIG = 12'hc10;
  localparam logic [11:0] FSI_IDX_IRQ_ENABLE = 12'hc18;
  localparam logic [11:0] FSI_IDX_IRQ_PENDING = 12'hc19;
  localparam logic [11:0] FSI_IDX_IRQ_CLEAR = 12'hc1a;
  localparam logic [13:0] FSI_ADDR_CONFIG = {FSI_IDX_CONFIG, 2'b00};
  localparam logic [13:0] FSI_ADDR_IRQ_ENABLE = {FSI_IDX_IRQ_ENABLE, 2'b00};
  localparam logic [13:0] FSI_ADDR_IRQ_PENDING = {FSI_IDX_IRQ_PENDING, 2'b00};
  localparam logic [13:0] FSI_ADDR_IRQ_CLEAR = {FSI_IDX_IRQ_CLEAR, 2'b00};

  localparam int FSI_NUM_EVENTS = 10;
  localparam int FSI_BYPASS_POS = 9;

  // Event bit positions, shared by enable, pending and clear registers
  localparam int FSI_EV_FAR_END_FAULT = 9;
  localparam int FSI_EV_TX_FIFO_FULL = 8;
  localparam int FSI_EV_TX_FIFO_EMPTY = 7;
  localparam int FSI_EV_RX_FIFO_FULL = 6;
  localparam int FSI_EV_RX_FIFO_EMPTY = 5;
  localparam int FSI_EV_LINK_CHANGE = 4;
  localparam int FSI_EV_REMOTE_FAULT = 3;
  localparam int FSI_EV_PRIO_FAIL = 2;
  localparam int FSI_EV_NEXT_PAGE = 1;
  localparam int FSI_EV_BASE_PAGE = 0;

  localparam logic [15:0] FSI_CONFIG_RESET = 16'h0000;
  localparam logic [9:0] FSI_ENABLE_RESET = 10'h3ff;
  localparam logic [9:0] FSI_PENDING_RESET = 10'h000;

  typedef struct packed {
    logic [13:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } fsi_req_t;

endpackage : fsi_pkg

// ### src/fsi_irq_status.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
// Operation
// RQ1 - Config bit 9 chooses signal detect: 0 uses pin, 1 ignores pin.
// RQ2 - Enable bit 9 gates far-end fault interrupt; resets enabled.
// RQ3 - Enable bit 8 gates transmit FIFO full interrupt; resets enabled.
// RQ4 - Enable bit 7 gates transmit FIFO empty interrupt; resets enabled.
// RQ5 - Enable bit 6 gates receive FIFO full interrupt; resets enabled.
// RQ6 - Enable bit 5 gates receive FIFO empty interrupt; resets enabled.
// RQ7 - Enable bit 4 gates link status change interrupt; resets enabled.
// RQ8 - Enable bit 3 gates partner remote fault interrupt; resets enabled.
// RQ9 - Enable bit 2 gates priority resolution failure interrupt; resets enabled.
// RQ10 - Enable bit 1 gates partner next page interrupt; resets enabled.
// RQ11 - Enable bit 0 gates partner base page interrupt; resets enabled.
// RQ12 - Status bit 8 latches transmit FIFO full, clears on read.
// RQ13 - Status bit 7 latches transmit FIFO empty, clears on read.
// RQ14 - Status bit 6 latches receive FIFO full, clears on read.
// RQ15 - Status bit 5 latches receive FIFO empty, clears on read.
// RQ16 - Status bits 9 and 4..0 latch their events, clear on read.
// RQ17 - Interrupt high while any pending bit has its enable set.
// RQ18 - Upper bits read zero, ignore writes; event beats clearing read.
module fsi_irq_status
  import fsi_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register port
  input wire logic [13:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Event pulses from the fiber/SGMII path, same clock
  input wire logic [9:0] event_in,
  // Signal detect
  input wire logic signal_detect_pin,
  output logic signal_detect,
  output logic signal_detect_bypass,
  // Interrupt
  output logic irq
);

  fsi_req_t req;
  logic sd_meta_ff;
  logic sd_sync_ff;
  logic bypass_ff;
  logic [31:0] rdata_ff;
  logic nxt_bypass;
  logic enable_wr;
  logic [9:0] enable_vec;
  logic [9:0] pending_vec;
  logic [9:0] request_vec;
  // Per-source enable bits, as software sees them
  logic far_end_fault_irq_enable;
  logic fifo_tx_full_irq_enable;
  logic fifo_tx_empty_irq_enable;
  logic fifo_rx_full_irq_enable;
  logic fifo_rx_empty_irq_enable;
  logic link_change_irq_enable;
  logic partner_remote_fault_irq_enable;
  logic priority_resolution_fail_irq_enable;
  logic partner_next_page_irq_enable;
  logic partner_base_page_irq_enable;
  // Per-source sticky pending bits
  logic far_end_fault_pending;
  logic fifo_tx_full_pending;
  logic fifo_tx_empty_pending;
  logic fifo_rx_full_pending;
  logic fifo_rx_empty_pending;
  logic link_change_pending;
  logic partner_remote_fault_pending;
  logic priority_resolution_fail_pending;
  logic partner_next_page_pending;
  logic partner_base_page_pending;
  logic [31:0] nxt_rdata;
  logic [9:0] clear_mask;
  wire sel_config;
  wire sel_enable;
  wire sel_pending;
  wire sel_clear;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  assign sel_config = req.addr == FSI_ADDR_CONFIG;
  assign sel_enable = req.addr == FSI_ADDR_IRQ_ENABLE;
  assign sel_pending = req.addr == FSI_ADDR_IRQ_PENDING;
  assign sel_clear = req.addr == FSI_ADDR_IRQ_CLEAR;

  // Config stores bit 9 only and enable stores bits 9..0; other write data is dropped
  assign nxt_bypass = (req.wr && sel_config) ? req.wdata[FSI_BYPASS_POS] : bypass_ff; // [RQ1] [RQ18]
  // Enable register gates all ten sources, bit per source
  assign enable_wr = req.wr && sel_enable; // [RQ2] [RQ3] [RQ4] [RQ5] [RQ6] [RQ7] [RQ8] [RQ9] [RQ10] [RQ11] [RQ18]

  // A read of the pending register clears all; the clear register clears selected bits
  always_comb begin
    clear_mask = '0;
    if (req.rd && sel_pending) begin
      clear_mask = '1;
    end else if (req.wr && sel_clear) begin
      clear_mask = req.wdata[FSI_NUM_EVENTS-1:0];
    end
  end

  // Register images, bit 9 first
  assign enable_vec = {
    far_end_fault_irq_enable,
    fifo_tx_full_irq_enable,
    fifo_tx_empty_irq_enable,
    fifo_rx_full_irq_enable,
    fifo_rx_empty_irq_enable,
    link_change_irq_enable,
    partner_remote_fault_irq_enable,
    priority_resolution_fail_irq_enable,
    partner_next_page_irq_enable,
    partner_base_page_irq_enable
  };
  assign pending_vec = {
    far_end_fault_pending,
    fifo_tx_full_pending,
    fifo_tx_empty_pending,
    fifo_rx_full_pending,
    fifo_rx_empty_pending,
    link_change_pending,
    partner_remote_fault_pending,
    priority_resolution_fail_pending,
    partner_next_page_pending,
    partner_base_page_pending
  }; // [RQ12] [RQ13] [RQ14] [RQ15] [RQ16]

  always_comb begin
    nxt_rdata = '0;
    if (req.rd) begin
      if (sel_config) begin
        nxt_rdata[FSI_BYPASS_POS] = bypass_ff; // [RQ18]
      end else if (sel_enable) begin
        nxt_rdata[FSI_NUM_EVENTS-1:0] = enable_vec;
      end else if (sel_pending) begin
        nxt_rdata[FSI_NUM_EVENTS-1:0] = pending_vec;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sd_meta_ff <= 1'b0;
      sd_sync_ff <= 1'b0;
      bypass_ff <= FSI_CONFIG_RESET[FSI_BYPASS_POS];
      rdata_ff <= '0;
    end else if (clk_en) begin
      sd_meta_ff <= signal_detect_pin;
      sd_sync_ff <= sd_meta_ff;
      bypass_ff <= nxt_bypass;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  // Bypass forces signal present so the fiber path ignores the pin
  assign signal_detect = bypass_ff | sd_sync_ff; // [RQ1]
  assign signal_detect_bypass = bypass_ff;
  assign irq = |request_vec; // [RQ17]

  // Far-end fault
  fsi_irq_source #(
    .ENABLE_INIT(FSI_ENABLE_RESET[FSI_EV_FAR_END_FAULT]),
    .PENDING_INIT(FSI_PENDING_RESET[FSI_EV_FAR_END_FAULT])
  ) u_far_end_fault (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .enable_wr(enable_wr),
    .enable_val(req.wdata[FSI_EV_FAR_END_FAULT]),
    .clear(clear_mask[FSI_EV_FAR_END_FAULT]),
    .event_pulse(event_in[FSI_EV_FAR_END_FAULT]),
    .enable(far_end_fault_irq_enable),
    .pending(far_end_fault_pending),
    .request(request_vec[FSI_EV_FAR_END_FAULT])
  ); // [RQ2] [RQ16]

  // Transmit FIFO full
  fsi_irq_source #(
    .ENABLE_INIT(FSI_ENABLE_RESET[FSI_EV_TX_FIFO_FULL]),
    .PENDING_INIT(FSI_PENDING_RESET[FSI_EV_TX_FIFO_FULL])
  ) u_tx_fifo_full (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .enable_wr(enable_wr),
    .enable_val(req.wdata[FSI_EV_TX_FIFO_FULL]),
    .clear(clear_mask[FSI_EV_TX_FIFO_FULL]),
    .event_pulse(event_in[FSI_EV_TX_FIFO_FULL]),
    .enable(fifo_tx_full_irq_enable),
    .pending(fifo_tx_full_pending),
    .request(request_vec[FSI_EV_TX_FIFO_FULL])
  ); // [RQ3] [RQ12]

  // Transmit FIFO empty
  fsi_irq_source #(
    .ENABLE_INIT(FSI_ENABLE_RESET[FSI_EV_TX_FIFO_EMPTY]),
    .PENDING_INIT(FSI_PENDING_RESET[FSI_EV_TX_FIFO_EMPTY])
  ) u_tx_fifo_empty (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .enable_wr(enable_wr),
    .enable_val(req.wdata[FSI_EV_TX_FIFO_EMPTY]),
    .clear(clear_mask[FSI_EV_TX_FIFO_EMPTY]),
    .event_pulse(event_in[FSI_EV_TX_FIFO_EMPTY]),
    .enable(fifo_tx_empty_irq_enable),
    .pending(fifo_tx_empty_pending),
    .request(request_vec[FSI_EV_TX_FIFO_EMPTY])
  ); // [RQ4] [RQ13]

  // Receive FIFO full
  fsi_irq_source #(
    .ENABLE_INIT(FSI_ENABLE_RESET[FSI_EV_RX_FIFO_FULL]),
    .PENDING_INIT(FSI_PENDING_RESET[FSI_EV_RX_FIFO_FULL])
  ) u_rx_fifo_full (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .enable_wr(enable_wr),
    .enable_val(req.wdata[FSI_EV_RX_FIFO_FULL]),
    .clear(clear_mask[FSI_EV_RX_FIFO_FULL]),
    .event_pulse(event_in[FSI_EV_RX_FIFO_FULL]),
    .enable(fifo_rx_full_irq_enable),
    .pending(fifo_rx_full_pending),
    .request(request_vec[FSI_EV_RX_FIFO_FULL])
  ); // [RQ5] [RQ14]

  // Receive FIFO empty
  fsi_irq_source #(
    .ENABLE_INIT(FSI_ENABLE_RESET[FSI_EV_RX_FIFO_EMPTY]),
    .PENDING_INIT(FSI_PENDING_RESET[FSI_EV_RX_FIFO_EMPTY])
  ) u_rx_fifo_empty (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .enable_wr(enable_wr),
    .enable_val(req.wdata[FSI_EV_RX_FIFO_EMPTY]),
    .clear(clear_mask[FSI_EV_RX_FIFO_EMPTY]),
    .event_pulse(event_in[FSI_EV_RX_FIFO_EMPTY]),
    .enable(fifo_rx_empty_irq_enable),
    .pending(fifo_rx_empty_pending),
    .request(request_vec[FSI_EV_RX_FIFO_EMPTY])
  ); // [RQ6] [RQ15]

  // Link status change
  fsi_irq_source #(
    .ENABLE_INIT(FSI_ENABLE_RESET[FSI_EV_LINK_CHANGE]),
    .PENDING_INIT(FSI_PENDING_RESET[FSI_EV_LINK_CHANGE])
  ) u_link_change (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .enable_wr(enable_wr),
    .enable_val(req.wdata[FSI_EV_LINK_CHANGE]),
    .clear(clear_mask[FSI_EV_LINK_CHANGE]),
    .event_pulse(event_in[FSI_EV_LINK_CHANGE]),
    .enable(link_change_irq_enable),
    .pending(link_change_pending),
    .request(request_vec[FSI_EV_LINK_CHANGE])
  ); // [RQ7] [RQ16]

  // Partner remote fault
  fsi_irq_source #(
    .ENABLE_INIT(FSI_ENABLE_RESET[FSI_EV_REMOTE_FAULT]),
    .PENDING_INIT(FSI_PENDING_RESET[FSI_EV_REMOTE_FAULT])
  ) u_remote_fault (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .enable_wr(enable_wr),
    .enable_val(req.wdata[FSI_EV_REMOTE_FAULT]),
    .clear(clear_mask[FSI_EV_REMOTE_FAULT]),
    .event_pulse(event_in[FSI_EV_REMOTE_FAULT]),
    .enable(partner_remote_fault_irq_enable),
    .pending(partner_remote_fault_pending),
    .request(request_vec[FSI_EV_REMOTE_FAULT])
  ); // [RQ8] [RQ16]

  // Priority resolution failure
  fsi_irq_source #(
    .ENABLE_INIT(FSI_ENABLE_RESET[FSI_EV_PRIO_FAIL]),
    .PENDING_INIT(FSI_PENDING_RESET[FSI_EV_PRIO_FAIL])
  ) u_prio_fail (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .enable_wr(enable_wr),
    .enable_val(req.wdata[FSI_EV_PRIO_FAIL]),
    .clear(clear_mask[FSI_EV_PRIO_FAIL]),
    .event_pulse(event_in[FSI_EV_PRIO_FAIL]),
    .enable(priority_resolution_fail_irq_enable),
    .pending(priority_resolution_fail_pending),
    .request(request_vec[FSI_EV_PRIO_FAIL])
  ); // [RQ9] [RQ16]

  // Partner next page received
  fsi_irq_source #(
    .ENABLE_INIT(FSI_ENABLE_RESET[FSI_EV_NEXT_PAGE]),
    .PENDING_INIT(FSI_PENDING_RESET[FSI_EV_NEXT_PAGE])
  ) u_next_page (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .enable_wr(enable_wr),
    .enable_val(req.wdata[FSI_EV_NEXT_PAGE]),
    .clear(clear_mask[FSI_EV_NEXT_PAGE]),
    .event_pulse(event_in[FSI_EV_NEXT_PAGE]),
    .enable(partner_next_page_irq_enable),
    .pending(partner_next_page_pending),
    .request(request_vec[FSI_EV_NEXT_PAGE])
  ); // [RQ10] [RQ16]

  // Partner base page received
  fsi_irq_source #(
    .ENABLE_INIT(FSI_ENABLE_RESET[FSI_EV_BASE_PAGE]),
    .PENDING_INIT(FSI_PENDING_RESET[FSI_EV_BASE_PAGE])
  ) u_base_page (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .enable_wr(enable_wr),
    .enable_val(req.wdata[FSI_EV_BASE_PAGE]),
    .clear(clear_mask[FSI_EV_BASE_PAGE]),
    .event_pulse(event_in[FSI_EV_BASE_PAGE]),
    .enable(partner_base_page_irq_enable),
    .pending(partner_base_page_pending),
    .request(request_vec[FSI_EV_BASE_PAGE])
  ); // [RQ11] [RQ16]

endmodule : fsi_irq_status

// One interrupt source: enable bit, sticky pending bit and its request
module fsi_irq_source
  import fsi_pkg::*;
#(
  parameter logic ENABLE_INIT = 1'b1,
  parameter logic PENDING_INIT = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Software side
  input wire logic enable_wr,
  input wire logic enable_val,
  input wire logic clear,
  // Event side
  input wire logic event_pulse,
  output logic enable,
  output logic pending,
  output logic request
);

  logic enable_ff;
  logic pending_ff;
  logic nxt_enable;
  logic nxt_pending;

  assign nxt_enable = enable_wr ? enable_val : enable_ff;
  // Set wins over clear so an event in the clearing cycle is kept for the next read
  assign nxt_pending = (pending_ff & ~clear) | event_pulse; // [RQ18]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_ff <= ENABLE_INIT;
      pending_ff <= PENDING_INIT;
    end else if (clk_en) begin
      enable_ff <= nxt_enable;
      pending_ff <= nxt_pending;
    end
  end

  assign enable = enable_ff;
  assign pending = pending_ff;
  assign request = pending_ff & enable_ff;

endmodule : fsi_irq_source

// ### tb/fsi_irq_status_chk.sv
`timescale 1ns/1ps
module fsi_chk
  import fsi_pkg::*;
(
  // Watched ports
  input wire logic clk, rst_n, clk_en, reg_wr, reg_rd, signal_detect_pin,
  input wire logic signal_detect, signal_detect_bypass, irq,
  input wire logic [13:0] reg_addr,
  input wire logic [31:0] reg_wdata, reg_rdata,
  input wire logic [9:0] event_in
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n || !clk_en);
  a_upper_zero: assert property (reg_rdata[31:10] == 0) else $error("upper");
  a_rdata_only: assert property (reg_rdata != 0 |-> $past(reg_rd)) else $error("rdata");
  a_bypass_wr: assert property (reg_wr && reg_addr == FSI_ADDR_CONFIG |=>
    signal_detect_bypass == $past(reg_wdata[9])) else $error("bypass");
  a_bypass_on: assert property (signal_detect_bypass |-> signal_detect) else $error("sd");
  a_pin_used: assert property ((!signal_detect_bypass && $stable(signal_detect_pin)) [*3] |->
    signal_detect == signal_detect_pin) else $error("pin");
  a_read_clears: assert property (reg_rd && reg_addr == FSI_ADDR_IRQ_PENDING && event_in == 0 |=> !irq)
    else $error("clr");
  a_irq_sticky: assert property ($past(irq) && !$past(reg_rd) && !$past(reg_wr) |-> irq)
    else $error("sticky");
  a_irq_cause: assert property ($rose(irq) |-> $past(event_in) != 0 || $past(reg_wr))
    else $error("cause");
  cover property (irq);
  cover property ($fell(irq));
  cover property (signal_detect_bypass);
  cover property (reg_wr && reg_addr == FSI_ADDR_IRQ_CLEAR);
endmodule : fsi_chk

// ### tb/fsi_irq_status_tb.sv
`timescale 1ns/1ps
module fsi_irq_status_tb;
  import fsi_pkg::*;
  localparam logic [13:0] C = FSI_ADDR_CONFIG, E = FSI_ADDR_IRQ_ENABLE, P = FSI_ADDR_IRQ_PENDING;
  logic clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, pin = 0, en = 1, sd, byp, irq;
  logic [13:0] ad = 0;
  logic [31:0] wd = 0, rdat;
  logic [9:0] ev_in = 0;
  int mismatches = 0, cmp_count = 0;
  always #50 clk = ~clk;
  fsi_irq_status dut (.clk(clk), .rst_n(rst_n), .clk_en(en), .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr_s),
    .reg_rd(rd_s), .reg_rdata(rdat), .event_in(ev_in), .signal_detect_pin(pin), .signal_detect(sd),
    .signal_detect_bypass(byp), .irq(irq));
  task chk(string n, logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task wr(logic [13:0] a, logic [31:0] d);
    @(posedge clk) {wr_s, ad, wd} <= {1'b1, a, d};
    @(posedge clk) wr_s <= 0;
    #1;
  endtask : wr
  task rd(logic [13:0] a, logic [31:0] e);
    @(posedge clk) {rd_s, ad} <= {1'b1, a};
    @(posedge clk) rd_s <= 0;
    #1 chk("rdata", rdat, e);
  endtask : rd
  task ev(logic [9:0] v);
    @(posedge clk) ev_in <= v;
    @(posedge clk) ev_in <= 0;
    #1;
  endtask : ev
  task t_gate;
    for (int i = 0; i < 10; i++) begin
      wr(E, 32'h3ff ^ (32'h1 << i));
      ev(10'h1 << i);
      chk("irq", irq, 0);
      wr(E, 32'h1 << i);
      chk("irq", irq, 1);
      rd(P, 32'h1 << i);
      chk("irq", irq, 0);
      rd(P, 0);
    end
  endtask : t_gate
  task t_misc;
    wr(E, 32'hffff_ffff);
    rd(E, 32'h3ff);
    wr(C, 32'h200);
    chk("sd", sd, 1);
    chk("byp", byp, 1);
    rd(C, 32'h200);
    wr(C, 0);
    chk("sd", sd, 0);
    chk("byp", byp, 0);
    @(posedge clk) pin <= 1;
    repeat (3) @(posedge clk);
    #1 chk("sd", sd, 1);
    // Event in the clearing read's cycle must survive
    @(posedge clk) {rd_s, ad, ev_in} <= {1'b1, P, 10'h10};
    @(posedge clk) {rd_s, ev_in} <= 0;
    rd(P, 32'h10);
    rd(14'h0, 0);
  endtask : t_misc
  task t_clr;
    ev(10'h3ff);
    chk("irq", irq, 1);
    wr(FSI_ADDR_IRQ_CLEAR, 32'h201);
    rd(P, 32'h1fe);
    chk("irq", irq, 0);
  endtask : t_clr
  task t_hold;
    // Event while frozen must be lost
    @(posedge clk) {en, ev_in} <= {1'b0, 10'h1};
    @(posedge clk) ev_in <= 0;
    @(posedge clk) en <= 1;
    #1 chk("irq", irq, 0);
    rd(P, 0);
  endtask : t_hold
  task close_out;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    rd(C, 0);
    rd(E, 32'h3ff);
    t_gate;
    t_misc;
    t_clr;
    t_hold;
    close_out;
  end
endmodule : fsi_irq_status_tb
bind fsi_irq_status fsi_chk chk (.*);
